/* File: logic/mivec_defines.svh */
// Constants of the interrupt vectoring block: offsets, bits, resets.
// Assumes one instruction cycle per CORE_CLK edge.
`ifndef MIVEC_DEFINES_SVH
`define MIVEC_DEFINES_SVH
// Register offsets on the 8-bit register port
`define MIVEC_OFS_OPTION 8'h81
`define MIVEC_OFS_CORE_CTL 8'h0b
`define MIVEC_OFS_PFLAG 8'h0c
`define MIVEC_OFS_PEN 8'h8c
`define MIVEC_OFS_PCPIN 8'h96
// Core control register bit positions
`define MIVEC_B_GLB_EN 7
`define MIVEC_B_PERIPH_EN 6
`define MIVEC_B_TMR_EN 5
`define MIVEC_B_EXT_EN 4
`define MIVEC_B_PC_EN 3
`define MIVEC_B_TMR_FLAG 2
`define MIVEC_B_EXT_FLAG 1
`define MIVEC_B_PC_FLAG 0
// Edge select bit inside the option register
`define MIVEC_B_EDGE_SEL 6
// Reset values
`define MIVEC_RST_CORE_CTL 8'h00
`define MIVEC_RST_PFLAG 8'h00
`define MIVEC_RST_PEN 8'h00
`define MIVEC_RST_PCPIN 6'h00
`define MIVEC_RST_EDGE_SEL 1'b1
// Fixed vector and timer wrap values
`define MIVEC_VECTOR 13'h0004
`define MIVEC_TMR_MAX 8'hff
`define MIVEC_TMR_ZERO 8'h00
// Source counts
`define MIVEC_NUM_SRC 11
`define MIVEC_NUM_PERIPH 7
`endif

/* File: logic/mivec_pkg.sv */
// Types shared by the interrupt vectoring block.
// Assumes nothing of its surroundings.
package mivec_pkg;
  // Sequencer states, Gray coded along run -> wake -> post
  typedef enum logic [1:0]
  {
    MIVEC_RUN = 2'b00,
    MIVEC_WAKE = 2'b01,
    MIVEC_POST = 2'b11
  } mivec_state_e;
endpackage

/* File: logic/mivec_ctrl.sv */
// Interrupt collection, masking, vectoring and sleep wake-up.
// Assumes the core pulses RETURN_FROM_IRQ_INSTR on a return from irq,
// holds SLEEP_ACT while asleep and executes one instruction after wake.
`include "mivec_defines.svh"

// How it works
// RULE_01 - Eleven sources: pin, timer, port, seven peripherals; the code has ten
// RULE_02 - Global enable gates every enabled request
// RULE_03 - Per-source enable blocks that source only
// RULE_04 - Reset clears the global enable
// RULE_05 - Taking: clear global, push, vector 0004h
// RULE_06 - Return instruction sets the global enable
// RULE_07 - Pin, port, timer flags in core register
// RULE_08 - Peripheral flags and enables in own registers
// RULE_09 - External events vectored after three cycles
// RULE_10 - Software clears flags before re-enabling
// RULE_11 - Flags set regardless of any enable
// RULE_12 - Clearing global drops next-cycle take, keeps pending
// RULE_13 - Wake with global set: next instruction, vector
// RULE_14 - Wake signalled by an enabled set flag
// RULE_15 - Wake: status bit4 set, bit3 clear
// RULE_16 - Pin request edge chosen by edge select
// RULE_17 - Timer wrap FF to 00 sets flag
// RULE_18 - Request is AND of flag and enable, gated
module mivec_ctrl
  import mivec_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Event sources
  input wire logic EXT_REQUEST_PIN,
  input wire logic [5:0] PORT_PINS,
  input wire logic [7:0] TIMER_COUNT,
  input wire logic [6:0] PERIPH_EVT,
  // Core side
  input wire logic RETURN_FROM_IRQ_INSTR,
  input wire logic SLEEP_ACT,
  output logic IRQ_TAKE,
  output logic [12:0] IRQ_VECTOR,
  output logic GLOBAL_IRQ_ENABLE,
  output logic IRQ,
  output logic WAKE,
  output logic STATUS_WR,
  output logic STATUS_TO,
  output logic STATUS_PD
);

  logic [7:0] ctl_q, ctl_d;
  logic [6:0] pflag_q, pflag_d;
  logic [6:0] pen_q, pen_d;
  logic [5:0] pcpin_q, pcpin_d;
  logic edge_sel_q, edge_sel_d;
  logic ext_prev_q;
  logic [5:0] port_prev_q;
  logic [7:0] tmr_prev_q;
  logic [7:0] rdata_q, rdata_d;
  mivec_state_e st_q, st_d;
  logic take_q, take_d;
  logic req_q, req_d;
  logic wake_q, wake_d;
  logic [12:0] vec_q;
  logic ext_evt, port_evt, tmr_evt, any_src, glb_clr_wr;
  logic wr_ctl, wr_pflag;

  // Source event detection from the previous-cycle samples
  assign ext_evt = edge_sel_q ? (EXT_REQUEST_PIN && !ext_prev_q)
                              : (!EXT_REQUEST_PIN && ext_prev_q); // RULE_16
  assign port_evt = |((PORT_PINS ^ port_prev_q) & pcpin_q); // RULE_01
  assign tmr_evt = (tmr_prev_q == `MIVEC_TMR_MAX) &&
                   (TIMER_COUNT == `MIVEC_TMR_ZERO); // RULE_17
  assign wr_ctl = REG_WR && (REG_ADDR == `MIVEC_OFS_CORE_CTL);
  assign wr_pflag = REG_WR && (REG_ADDR == `MIVEC_OFS_PFLAG);
  // A write leaving the global enable clear cancels a take in flight
  assign glb_clr_wr = wr_ctl && !REG_WDATA[`MIVEC_B_GLB_EN];

  // Enabled source present, independent of the global enable
  assign any_src =
    (ctl_q[`MIVEC_B_EXT_EN] && ctl_q[`MIVEC_B_EXT_FLAG]) ||
    (ctl_q[`MIVEC_B_PC_EN] && ctl_q[`MIVEC_B_PC_FLAG]) ||
    (ctl_q[`MIVEC_B_TMR_EN] && ctl_q[`MIVEC_B_TMR_FLAG]) ||
    (ctl_q[`MIVEC_B_PERIPH_EN] && |(pflag_q & pen_q)); // RULE_03

  // Register next values; hardware flag set wins over software clear
  always_comb
  begin
    ctl_d = ctl_q;
    pflag_d = pflag_q;
    pen_d = pen_q;
    pcpin_d = pcpin_q;
    edge_sel_d = edge_sel_q;
    if (wr_ctl)
    begin
      ctl_d[7:3] = REG_WDATA[7:3];
      ctl_d[2:0] = ctl_q[2:0] & ~REG_WDATA[2:0]; // RULE_10
    end
    if (wr_pflag)
    begin
      pflag_d = pflag_q & ~REG_WDATA[6:0];
    end
    if (REG_WR && (REG_ADDR == `MIVEC_OFS_PEN))
    begin
      pen_d = REG_WDATA[6:0]; // RULE_08
    end
    if (REG_WR && (REG_ADDR == `MIVEC_OFS_PCPIN))
    begin
      pcpin_d = REG_WDATA[5:0];
    end
    if (REG_WR && (REG_ADDR == `MIVEC_OFS_OPTION))
    begin
      edge_sel_d = REG_WDATA[`MIVEC_B_EDGE_SEL];
    end
    // Flags set whatever the enables say
    if (ext_evt)
    begin
      ctl_d[`MIVEC_B_EXT_FLAG] = 1'b1; // RULE_11
    end
    if (port_evt)
    begin
      ctl_d[`MIVEC_B_PC_FLAG] = 1'b1; // RULE_07
    end
    if (tmr_evt)
    begin
      ctl_d[`MIVEC_B_TMR_FLAG] = 1'b1;
    end
    pflag_d = pflag_d | PERIPH_EVT; // RULE_11
    // Return sets global enable unless software writes it the same cycle
    if (RETURN_FROM_IRQ_INSTR && !wr_ctl)
    begin
      ctl_d[`MIVEC_B_GLB_EN] = 1'b1; // RULE_06
    end
    if (take_d)
    begin
      ctl_d[`MIVEC_B_GLB_EN] = 1'b0; // RULE_05
    end
  end

  // Request evaluation once per instruction cycle
  always_comb
  begin
    req_d = ctl_q[`MIVEC_B_GLB_EN] && any_src; // RULE_18 RULE_02
  end

  // Sequencer: normal takes, sleep wake-up and the post-wake instruction
  always_comb
  begin
    st_d = st_q;
    take_d = 1'b0;
    wake_d = 1'b0;
    unique case (st_q)
      MIVEC_RUN:
      begin
        if (SLEEP_ACT && any_src)
        begin
          wake_d = 1'b1; // RULE_14
          st_d = MIVEC_WAKE;
        end
        else if (req_q && ctl_q[`MIVEC_B_GLB_EN] && !glb_clr_wr &&
                 !SLEEP_ACT)
        begin
          take_d = 1'b1; // RULE_12 RULE_09
        end
      end
      MIVEC_WAKE:
      begin
        // Core wakes now; it runs the instruction after the sleep in MIVEC_POST
        st_d = ctl_q[`MIVEC_B_GLB_EN] ? MIVEC_POST : MIVEC_RUN; // RULE_13
      end
      MIVEC_POST:
      begin
        st_d = MIVEC_RUN;
        take_d = ctl_q[`MIVEC_B_GLB_EN] && !glb_clr_wr; // RULE_13
      end
      default:
      begin
        st_d = MIVEC_RUN;
      end
    endcase
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        `MIVEC_OFS_CORE_CTL: rdata_d = ctl_q;
        `MIVEC_OFS_PFLAG: rdata_d = {1'b0, pflag_q};
        `MIVEC_OFS_PEN: rdata_d = {1'b0, pen_q};
        `MIVEC_OFS_PCPIN: rdata_d = {2'h0, pcpin_q};
        `MIVEC_OFS_OPTION: rdata_d = {1'b0, edge_sel_q, 6'h00};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // State registers; synchronous active-low reset
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      ctl_q <= `MIVEC_RST_CORE_CTL; // RULE_04
      pflag_q <= 7'(`MIVEC_RST_PFLAG);
      pen_q <= 7'(`MIVEC_RST_PEN);
      pcpin_q <= `MIVEC_RST_PCPIN;
      edge_sel_q <= `MIVEC_RST_EDGE_SEL;
      // Pins sampled in reset, so release brings no false edge or wrap
      ext_prev_q <= EXT_REQUEST_PIN;
      port_prev_q <= PORT_PINS;
      tmr_prev_q <= TIMER_COUNT;
      rdata_q <= 8'h00;
      st_q <= MIVEC_RUN;
      take_q <= 1'b0;
      req_q <= 1'b0;
      wake_q <= 1'b0;
      vec_q <= 13'h0000;
    end
    else
    begin
      ctl_q <= ctl_d;
      pflag_q <= pflag_d;
      pen_q <= pen_d;
      pcpin_q <= pcpin_d;
      edge_sel_q <= edge_sel_d;
      ext_prev_q <= EXT_REQUEST_PIN;
      port_prev_q <= PORT_PINS;
      tmr_prev_q <= TIMER_COUNT;
      rdata_q <= rdata_d;
      st_q <= st_d;
      take_q <= take_d;
      req_q <= req_d;
      wake_q <= wake_d;
      vec_q <= `MIVEC_VECTOR; // RULE_05
    end
  end

  // Outputs straight from flip-flops except STATUS_PD, tied low; status pattern fixed on wake
  assign REG_RDATA = rdata_q;
  assign IRQ_TAKE = take_q;
  assign IRQ_VECTOR = vec_q;
  assign GLOBAL_IRQ_ENABLE = ctl_q[`MIVEC_B_GLB_EN];
  assign IRQ = req_q;
  assign WAKE = wake_q;
  assign STATUS_WR = wake_q; // RULE_15
  assign STATUS_TO = wake_q;
  assign STATUS_PD = 1'b0;

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  // Take, return, enable gating and flag setting
  a_take_vector: assert property ( // RULE_05
    IRQ_TAKE |-> IRQ_VECTOR == 13'h0004 && !GLOBAL_IRQ_ENABLE)
    else $error("take without vector or with enable set");
  a_take_needs_glb: assert property ( // RULE_02
    $rose(IRQ_TAKE) |-> $past(GLOBAL_IRQ_ENABLE))
    else $error("take while global enable was clear");
  a_return_sets: assert property ( // RULE_06
    RETURN_FROM_IRQ_INSTR && !wr_ctl && !take_d |=> GLOBAL_IRQ_ENABLE)
    else $error("return did not set global enable");
  a_flag_sticky: assert property (PERIPH_EVT[0] |=> pflag_q[0]) // RULE_11
    else $error("peripheral flag not set by event");
  // A take of another source in flight clears the enable: excluded
  a_ext_latency: assert property ( // RULE_09
    st_q == MIVEC_RUN && ext_evt && ctl_q[`MIVEC_B_EXT_EN] &&
    ctl_q[`MIVEC_B_GLB_EN] && !take_d && !REG_WR && !SLEEP_ACT ##1
    !take_d && !REG_WR && !SLEEP_ACT ##1 !REG_WR && !SLEEP_ACT
    |-> ##[0:1] IRQ_TAKE)
    else $error("external event not vectored in time");
  a_glb_clear_blocks: assert property (glb_clr_wr |=> !IRQ_TAKE) // RULE_12
    else $error("take after global enable cleared");
  a_wake_status: assert property ( // RULE_15
    WAKE |-> STATUS_WR && STATUS_TO && !STATUS_PD)
    else $error("wrong status pattern on wake");
  a_wake_vector: assert property ( // RULE_13
    WAKE && GLOBAL_IRQ_ENABLE && !REG_WR ##1 !REG_WR |=> IRQ_TAKE)
    else $error("wake with enable did not vector after one instr");
  a_wake_cause: assert property ($rose(WAKE) |-> $past(any_src)) // RULE_14
    else $error("wake without enabled flag");
  a_tmr_wrap: assert property ( // RULE_17
    tmr_evt |=> ctl_q[`MIVEC_B_TMR_FLAG])
    else $error("timer wrap did not set flag");
  a_reset_glb: assert property ( // RULE_04
    @(posedge CORE_CLK) disable iff (1'b0) !RESET_N |=> !GLOBAL_IRQ_ENABLE)
    else $error("global enable set after reset");

  // Main scenarios to be reached
  c_take: cover property (IRQ_TAKE);
  c_wake_vector: cover property (WAKE ##2 IRQ_TAKE);
  c_glb_cancel: cover property (req_q && glb_clr_wr);
  c_ret_reenable: cover property (RETURN_FROM_IRQ_INSTR ##1 GLOBAL_IRQ_ENABLE);
  c_ext_take: cover property (ext_evt ##3 IRQ_TAKE);

endmodule

/* File: bench/mivec_core_model.sv */
// Core model: fetch counter, one-deep return stack, sleep state.
// Assumes the bench pulses go_ret and go_sleep for one cycle.
module mivec_core_model
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Bench commands
  input wire logic go_ret,
  input wire logic go_sleep,
  // Controller side
  input wire logic IRQ_TAKE,
  input wire logic [12:0] IRQ_VECTOR,
  input wire logic WAKE,
  output logic RETURN_FROM_IRQ_INSTR,
  output logic SLEEP_ACT,
  output logic [12:0] pc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] top;
  // One instruction a cycle; pc frozen while asleep
  always @(posedge CORE_CLK)
  begin
    RETURN_FROM_IRQ_INSTR <= RESET_N & go_ret;
    if (!RESET_N)
    begin
      SLEEP_ACT <= 1'h0;
      pc <= 13'h0000;
      top <= 13'h0000;
    end
    else if (IRQ_TAKE)
    begin
      top <= pc;
      pc <= IRQ_VECTOR;
    end
    else if (WAKE)
      SLEEP_ACT <= 1'h0;
    else if (go_sleep)
      SLEEP_ACT <= 1'h1;
    else if (go_ret)
      pc <= top;
    else if (!SLEEP_ACT)
      pc <= pc + 13'h0001;
  end
endmodule

/* File: bench/mcu_interrupt_vectoring_bench.sv */
// Self-checking bench: register tasks, event pins, core model.
// Assumes the controller and its package are compiled before it.
`include "mivec_defines.svh"
module mcu_interrupt_vectoring_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, we = 1'h0, re = 1'h0, pin = 1'h0;
  logic go_ret = 1'h0, go_sleep = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, tmr = 8'h00, rdata;
  logic [5:0] port = 6'h00;
  logic [6:0] pevt = 7'h00;
  logic ret, slp, take, glb_en, irq, wake, swr, sto, spd;
  logic [12:0] vec, pc;
  int num_errors = 0, n_tests = 0, n_take = 0, n;

  // Core clock, 100 MHz
  always #5 clk = ~clk;
  // Take counter, so a stray take shows later
  always @(posedge clk)
    if (take === 1'h1)
      n_take <= n_take + 1;

  mivec_ctrl dut
  (
    .CORE_CLK(clk), .RESET_N(rst_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(we), .REG_RD(re),
    .REG_RDATA(rdata), .EXT_REQUEST_PIN(pin), .PORT_PINS(port),
    .TIMER_COUNT(tmr), .PERIPH_EVT(pevt), .RETURN_FROM_IRQ_INSTR(ret),
    .SLEEP_ACT(slp), .IRQ_TAKE(take), .IRQ_VECTOR(vec),
    .GLOBAL_IRQ_ENABLE(glb_en), .IRQ(irq), .WAKE(wake),
    .STATUS_WR(swr), .STATUS_TO(sto), .STATUS_PD(spd)
  );
  mivec_core_model core
  (
    .CORE_CLK(clk), .RESET_N(rst_n), .go_ret(go_ret),
    .go_sleep(go_sleep), .IRQ_TAKE(take), .IRQ_VECTOR(vec),
    .WAKE(wake), .RETURN_FROM_IRQ_INSTR(ret), .SLEEP_ACT(slp), .pc(pc)
  );

  // Compare and count
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'h1;
    @(posedge clk);
    we <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'h1;
    @(posedge clk);
    re <= 1'h0;
    #1 chk(rdata, e);
  endtask
  // Bounded wait for a take or a wake; n holds the edges seen
  task automatic wait_for(input bit w, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while ((w ? wake : take) !== 1'h1 && n < lim);
    if ((w ? wake : take) !== 1'h1)
    begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, 1'b0, 1'b1);
      wrap_up();
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    // Reset values, option bits, an unmapped place
    rd(`MIVEC_OFS_CORE_CTL, 8'h00);
    chk(glb_en, 13'h0000);
    rd(`MIVEC_OFS_OPTION, 8'h40);
    rd(8'h55, 8'h00);
    wr(`MIVEC_OFS_PCPIN, 8'h3f);
    rd(`MIVEC_OFS_PCPIN, 8'h3f);
    // Every source fires with all enables off
    @(posedge clk);
    pin <= 1'h1;
    tmr <= 8'hff;
    port <= 6'h01;
    pevt <= 7'h7f;
    @(posedge clk);
    tmr <= 8'h00;
    pevt <= 7'h00;
    rd(`MIVEC_OFS_CORE_CTL, 8'h07);
    rd(`MIVEC_OFS_PFLAG, 8'h7f);
    chk(13'(n_take), 13'h0000);
    wr(`MIVEC_OFS_CORE_CTL, 8'h07);
    wr(`MIVEC_OFS_PFLAG, 8'h7f);
    rd(`MIVEC_OFS_PFLAG, 8'h00);
    // Falling edge chosen: the pin drop counts
    wr(`MIVEC_OFS_OPTION, 8'h00);
    @(posedge clk);
    pin <= 1'h0;
    rd(`MIVEC_OFS_CORE_CTL, 8'h02);
    wr(`MIVEC_OFS_CORE_CTL, 8'h02);
    wr(`MIVEC_OFS_OPTION, 8'h40);
    // Peripheral bit 0 pending, only bit 1 enabled
    wr(`MIVEC_OFS_CORE_CTL, 8'hc0);
    wr(`MIVEC_OFS_PEN, 8'h02);
    @(posedge clk);
    pevt <= 7'h01;
    @(posedge clk);
    pevt <= 7'h00;
    repeat (6) @(posedge clk);
    chk(13'(n_take), 13'h0000);
    wr(`MIVEC_OFS_PEN, 8'h01);
    wait_for(1'b0, 6);
    chk(vec, 13'h0004);
    chk(glb_en, 13'h0000);
    @(posedge clk);
    #1 chk(pc, 13'h0004);
    // Flag cleared before the return, so no second take
    wr(`MIVEC_OFS_PFLAG, 8'h01);
    @(posedge clk);
    go_ret <= 1'h1;
    @(posedge clk);
    go_ret <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk(glb_en, 13'h0001);
    repeat (4) @(posedge clk);
    chk(13'(n_take), 13'h0001);
    // Pin edge to take: three or four cycles
    wr(`MIVEC_OFS_CORE_CTL, 8'h90);
    @(posedge clk);
    pin <= 1'h1;
    wait_for(1'b0, 8);
    chk(n == 3 || n == 4, 13'h0001);
    // Global enable clear: new edge waits until it is set
    wr(`MIVEC_OFS_CORE_CTL, 8'h12);
    @(posedge clk);
    pin <= 1'h0;
    @(posedge clk);
    pin <= 1'h1;
    repeat (6) @(posedge clk);
    chk(irq, 13'h0000);
    rd(`MIVEC_OFS_CORE_CTL, 8'h12);
    wr(`MIVEC_OFS_CORE_CTL, 8'h90);
    wait_for(1'b0, 6);
    chk(irq, 13'h0001);
    // Asleep, a pin edge wakes; one instruction, then the take
    wr(`MIVEC_OFS_CORE_CTL, 8'h12);
    wr(`MIVEC_OFS_CORE_CTL, 8'h90);
    @(posedge clk);
    go_sleep <= 1'h1;
    pin <= 1'h0;
    @(posedge clk);
    go_sleep <= 1'h0;
    pin <= 1'h1;
    wait_for(1'b1, 8);
    chk({swr, sto, spd}, 13'h0006);
    wait_for(1'b0, 4);
    chk(13'(n), 13'h0002);
    wrap_up();
  end
endmodule
